// file: src/charger_regs_pkg.sv
package charger_regs_pkg;
    // ****************************************
    // serial bus
    // ****************************************
    localparam logic [6:0] DEVICE_ADDRESS = 7'h6b;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CONTROL_STATUS_MAIN_OFFSET = 8'h00;
    localparam logic [7:0] CHARGE_CONFIG_OFFSET = 8'h01;
    localparam logic [7:0] CONTROL_STATUS_MAIN_RESET = 8'h40;
    localparam logic [7:0] CHARGE_CONFIG_RESET = 8'h34;

    // control_status_main fields
    localparam int SAFETY_TIMER_KICK_BIT = 7;
    localparam int STATUS_PIN_ENABLE_BIT = 6;
    localparam int CHARGE_STATE_HI = 5;
    localparam int CHARGE_STATE_LO = 4;
    localparam int BOOST_BIT = 3;
    localparam int FAULT_HI = 2;
    localparam int FAULT_LO = 0;

    // charge_config fields
    localparam int INPUT_CURRENT_LIMIT_HI = 7;
    localparam int INPUT_CURRENT_LIMIT_LO = 6;
    localparam int WEAK_BATTERY_THRESHOLD_HI = 5;
    localparam int WEAK_BATTERY_THRESHOLD_LO = 4;
    localparam int TERMINATION_ENABLE_BIT = 3;
    localparam int CHARGE_ENABLE_N_BIT = 2;
    localparam int HIGH_IMPEDANCE_SELECT_BIT = 1;
    localparam int OPERATING_MODE_SELECT_BIT = 0;

    // weak battery threshold codes: 3.4 V, 3.5 V, 3.6 V, 3.7 V
    localparam logic [1:0] WEAK_BATTERY_3V4 = 2'h0;
    localparam logic [1:0] WEAK_BATTERY_3V5 = 2'h1;
    localparam logic [1:0] WEAK_BATTERY_3V6 = 2'h2;
    localparam logic [1:0] WEAK_BATTERY_3V7 = 2'h3;

    // ****************************************
    // fault codes
    // ****************************************
    typedef enum logic [2:0] {
        FAULT_NONE = 3'h0,
        FAULT_INPUT_OVERVOLTAGE = 3'h1,
        FAULT_SLEEP = 3'h2,
        FAULT_POOR_INPUT = 3'h3,
        FAULT_BATTERY_OVERVOLTAGE = 3'h4,
        FAULT_THERMAL_SHUTDOWN = 3'h5,
        FAULT_TIMER = 3'h6,
        FAULT_NO_BATTERY = 3'h7
    } fault_code_t;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_MHZ = 10;
    localparam int STATUS_PULSE_US = 128;
    localparam int STATUS_PULSE_CYCLES = STATUS_PULSE_US * CLOCK_MHZ;
    localparam int PULSE_COUNT_WIDTH = 11;

    // ****************************************
    // serial slave states
    // ****************************************
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_POINTER = 9'h008,
        ST_POINTER_ACK = 9'h010,
        ST_WRITE = 9'h020,
        ST_WRITE_ACK = 9'h040,
        ST_READ = 9'h080,
        ST_READ_ACK = 9'h100
    } slave_state_t;
endpackage : charger_regs_pkg

// file: src/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    // ****************************************
    // three stages, change taken once stages two and three agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    stage1 <= 1'b1;
                    stage2 <= 1'b1;
                    stage3 <= 1'b1;
                    level_out[i] <= 1'b1;
                end else begin
                    stage1 <= pin_in[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        level_out[i] <= stage3;
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

// file: src/charger_control_registers.sv
`timescale 1ns/10ps
module charger_control_registers (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic charging_in,
    input wire logic status_event_in,
    input wire logic boost_active_in,
    input wire logic [2:0] fault_code_in,
    output logic safety_timer_kick_out,
    output logic status_out,
    output logic status_oe_out,
    output logic [1:0] input_current_limit_out,
    output logic [1:0] weak_battery_threshold_out,
    output logic termination_enable_out,
    output logic charge_enable_n_out,
    output logic high_impedance_select_out,
    output logic operating_mode_select_out
);
    // ****************************************
    // pin conditioning
    // ****************************************
    logic [1:0] pins;
    logic scl;
    logic sda;
    logic scl_prev;
    logic sda_prev;

    pin_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pin_in({scl_in, sda_in}),
        .level_out(pins)
    );

    assign scl = pins[1];
    assign sda = pins[0];

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl;
            sda_prev <= sda;
        end
    end

    // scl and sda share the same latency, so their order is kept
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    assign start_seen = scl & scl_prev & sda_prev & ~sda;
    assign stop_seen = scl & scl_prev & ~sda_prev & sda;

    // ****************************************
    // register storage
    // ****************************************
    logic status_pin_enable;
    logic [1:0] input_current_limit;
    logic [1:0] weak_battery_threshold;
    logic termination_enable;
    logic charge_enable_n;
    logic high_impedance_select;
    logic operating_mode_select;
    charger_regs_pkg::fault_code_t fault;

    logic [7:0] pointer;
    logic write_strobe;
    logic read_done;
    logic [7:0] shift;
    logic [7:0] read_data;

    always_comb begin
        read_data = 8'h00;
        case (pointer)
            charger_regs_pkg::CONTROL_STATUS_MAIN_OFFSET: begin
                read_data[charger_regs_pkg::SAFETY_TIMER_KICK_BIT] = 1'b0;
                read_data[charger_regs_pkg::STATUS_PIN_ENABLE_BIT] = status_pin_enable;
                read_data[charger_regs_pkg::BOOST_BIT] = boost_active_in;
                read_data[charger_regs_pkg::FAULT_HI:charger_regs_pkg::FAULT_LO] = fault;
            end
            charger_regs_pkg::CHARGE_CONFIG_OFFSET: begin
                read_data[charger_regs_pkg::INPUT_CURRENT_LIMIT_HI:
                          charger_regs_pkg::INPUT_CURRENT_LIMIT_LO] = input_current_limit;
                read_data[charger_regs_pkg::WEAK_BATTERY_THRESHOLD_HI:
                          charger_regs_pkg::WEAK_BATTERY_THRESHOLD_LO] = weak_battery_threshold;
                read_data[charger_regs_pkg::TERMINATION_ENABLE_BIT] = termination_enable;
                read_data[charger_regs_pkg::CHARGE_ENABLE_N_BIT] = charge_enable_n;
                read_data[charger_regs_pkg::HIGH_IMPEDANCE_SELECT_BIT] = high_impedance_select;
                read_data[charger_regs_pkg::OPERATING_MODE_SELECT_BIT] = operating_mode_select;
            end
            default: begin
                read_data = 8'h00;
            end
        endcase
    end

    // unmapped offsets take writes silently
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_pin_enable <= charger_regs_pkg::CONTROL_STATUS_MAIN_RESET[
                charger_regs_pkg::STATUS_PIN_ENABLE_BIT];
            {input_current_limit, weak_battery_threshold, termination_enable,
             charge_enable_n, high_impedance_select, operating_mode_select}
                <= charger_regs_pkg::CHARGE_CONFIG_RESET;
        end else if (write_strobe) begin
            if (pointer == charger_regs_pkg::CONTROL_STATUS_MAIN_OFFSET) begin
                status_pin_enable <= shift[charger_regs_pkg::STATUS_PIN_ENABLE_BIT];
            end
            if (pointer == charger_regs_pkg::CHARGE_CONFIG_OFFSET) begin
                {input_current_limit, weak_battery_threshold, termination_enable,
                 charge_enable_n, high_impedance_select, operating_mode_select}
                    <= shift;
            end
        end
    end

    // kick is a pulse only; a written zero changes nothing
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            safety_timer_kick_out <= 1'b0;
        end else begin
            safety_timer_kick_out <= write_strobe
                && pointer == charger_regs_pkg::CONTROL_STATUS_MAIN_OFFSET
                && shift[charger_regs_pkg::SAFETY_TIMER_KICK_BIT];
        end
    end

    // ****************************************
    // fault report
    // ****************************************
    logic fault_read;
    logic fault_clear_on_read;
    assign fault_read = read_done && pointer == charger_regs_pkg::CONTROL_STATUS_MAIN_OFFSET;
    assign fault_clear_on_read = fault == charger_regs_pkg::FAULT_SLEEP
        || fault == charger_regs_pkg::FAULT_TIMER
        || fault == charger_regs_pkg::FAULT_NO_BATTERY;

    // a live fault wins over a read clear in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault <= charger_regs_pkg::FAULT_NONE;
        end else if (fault_code_in != charger_regs_pkg::FAULT_NONE) begin
            fault <= charger_regs_pkg::fault_code_t'(fault_code_in);
        end else if (!fault_clear_on_read || fault_read) begin
            fault <= charger_regs_pkg::FAULT_NONE;
        end
    end

    // ****************************************
    // status pin
    // ****************************************
    logic [charger_regs_pkg::PULSE_COUNT_WIDTH-1:0] pulse_count;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pulse_count <= '0;
        end else if (status_event_in) begin
            pulse_count <= charger_regs_pkg::PULSE_COUNT_WIDTH'(
                charger_regs_pkg::STATUS_PULSE_CYCLES);
        end else if (pulse_count != '0) begin
            pulse_count <= pulse_count - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_oe_out <= 1'b0;
        end else begin
            status_oe_out <= (status_pin_enable && charging_in) || pulse_count != '0;
        end
    end
    assign status_out = 1'b0;

    // ****************************************
    // serial slave
    // ****************************************
    charger_regs_pkg::slave_state_t state;
    logic [3:0] bit_count;
    logic read_mode;
    logic [7:0] tx;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= charger_regs_pkg::ST_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            read_mode <= 1'b0;
            pointer <= 8'h00;
            sda_oe_out <= 1'b0;
            write_strobe <= 1'b0;
            read_done <= 1'b0;
        end else begin
            write_strobe <= 1'b0;
            read_done <= 1'b0;
            if (start_seen) begin
                state <= charger_regs_pkg::ST_ADDR;
                bit_count <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (stop_seen) begin
                state <= charger_regs_pkg::ST_IDLE;
                sda_oe_out <= 1'b0;
            end else begin
                case (state)
                    charger_regs_pkg::ST_ADDR,
                    charger_regs_pkg::ST_POINTER,
                    charger_regs_pkg::ST_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda};
                            bit_count <= bit_count + 1'b1;
                        end else if (scl_fall && bit_count == charger_regs_pkg::BITS_PER_BYTE) begin
                            bit_count <= 4'h0;
                            if (state == charger_regs_pkg::ST_ADDR) begin
                                if (shift[7:1] == charger_regs_pkg::DEVICE_ADDRESS) begin
                                    read_mode <= shift[0];
                                    sda_oe_out <= 1'b1;
                                    state <= charger_regs_pkg::ST_ADDR_ACK;
                                end else begin
                                    state <= charger_regs_pkg::ST_IDLE;
                                end
                            end else if (state == charger_regs_pkg::ST_POINTER) begin
                                pointer <= shift;
                                sda_oe_out <= 1'b1;
                                state <= charger_regs_pkg::ST_POINTER_ACK;
                            end else begin
                                write_strobe <= 1'b1;
                                sda_oe_out <= 1'b1;
                                state <= charger_regs_pkg::ST_WRITE_ACK;
                            end
                        end
                    end
                    charger_regs_pkg::ST_ADDR_ACK,
                    charger_regs_pkg::ST_POINTER_ACK,
                    charger_regs_pkg::ST_WRITE_ACK: begin
                        if (write_strobe) begin
                            pointer <= pointer + 1'b1;
                        end
                        if (scl_fall) begin
                            sda_oe_out <= 1'b0;
                            if (state == charger_regs_pkg::ST_ADDR_ACK && read_mode) begin
                                tx <= read_data;
                                sda_oe_out <= ~read_data[7];
                                state <= charger_regs_pkg::ST_READ;
                            end else if (state == charger_regs_pkg::ST_ADDR_ACK) begin
                                state <= charger_regs_pkg::ST_POINTER;
                            end else begin
                                state <= charger_regs_pkg::ST_WRITE;
                            end
                        end
                    end
                    charger_regs_pkg::ST_READ: begin
                        if (scl_fall) begin
                            if (bit_count == charger_regs_pkg::BITS_PER_BYTE - 1'b1) begin
                                bit_count <= 4'h0;
                                sda_oe_out <= 1'b0;
                                read_done <= 1'b1;
                                state <= charger_regs_pkg::ST_READ_ACK;
                            end else begin
                                bit_count <= bit_count + 1'b1;
                                tx <= {tx[6:0], 1'b0};
                                sda_oe_out <= ~tx[6];
                            end
                        end
                    end
                    charger_regs_pkg::ST_READ_ACK: begin
                        if (read_done) begin
                            pointer <= pointer + 1'b1;
                        end
                        // a master nack ends the read; wait for stop or start
                        if (scl_rise && sda) begin
                            state <= charger_regs_pkg::ST_IDLE;
                        end else if (scl_fall) begin
                            tx <= read_data;
                            sda_oe_out <= ~read_data[7];
                            state <= charger_regs_pkg::ST_READ;
                        end
                    end
                    charger_regs_pkg::ST_IDLE: begin
                        sda_oe_out <= 1'b0;
                    end
                    default: begin
                        state <= charger_regs_pkg::ST_IDLE;
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign sda_out = 1'b0;

    // ****************************************
    // control outputs
    // ****************************************
    assign input_current_limit_out = input_current_limit;
    assign weak_battery_threshold_out = weak_battery_threshold;
    assign termination_enable_out = termination_enable;
    assign charge_enable_n_out = charge_enable_n;
    assign high_impedance_select_out = high_impedance_select;
    assign operating_mode_select_out = operating_mode_select;
endmodule : charger_control_registers

// file: bench/i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model (
    input wire logic clk_in,
    input wire logic sda_oe_in,
    output logic scl_out,
    output logic sda_out
);
    localparam int HALF = 16;
    logic pull_low;
    logic bus_nack;
    // open drain with pull-up: released line reads high
    assign sda_out = !(pull_low || sda_oe_in);
    initial begin
        scl_out = 1'b1;
        pull_low = 1'b0;
        bus_nack = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_clk
    // data moves a few clocks after scl falls so the slave never sees a false start
    task automatic bit_xfer(input logic b, output logic r);
        wait_clk(4);
        pull_low = !b;
        wait_clk(HALF - 4);
        scl_out = 1'b1;
        wait_clk(HALF);
        r = sda_out;
        scl_out = 1'b0;
    endtask : bit_xfer
    task automatic start_cond();
        wait_clk(4);
        pull_low = 1'b0;
        wait_clk(HALF - 4);
        scl_out = 1'b1;
        wait_clk(HALF);
        pull_low = 1'b1;
        wait_clk(HALF);
        scl_out = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        wait_clk(4);
        pull_low = 1'b1;
        wait_clk(HALF - 4);
        scl_out = 1'b1;
        wait_clk(HALF);
        pull_low = 1'b0;
        wait_clk(HALF);
    endtask : stop_cond
    task automatic byte_xfer(input logic [7:0] d, input logic ack_bit, input logic chk,
        output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
        bit_xfer(ack_bit, a);
        if (chk && a) bus_nack = 1'b1;
    endtask : byte_xfer
    task automatic write_regs(input logic [6:0] addr, input logic [7:0] ptr,
        input logic [7:0] d[$]);
        logic [7:0] q;
        start_cond();
        byte_xfer({addr, 1'b0}, 1'b1, 1'b1, q);
        byte_xfer(ptr, 1'b1, 1'b1, q);
        foreach (d[i]) byte_xfer(d[i], 1'b1, 1'b1, q);
        stop_cond();
    endtask : write_regs
    task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] d[$]);
        logic [7:0] q;
        d = {};
        start_cond();
        byte_xfer({charger_regs_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b1, q);
        byte_xfer(ptr, 1'b1, 1'b1, q);
        start_cond();
        byte_xfer({charger_regs_pkg::DEVICE_ADDRESS, 1'b1}, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            byte_xfer(8'hff, (i == n - 1), 1'b0, q);
            d.push_back(q);
        end
        stop_cond();
    endtask : read_regs
endmodule : i2c_host_model

// file: bench/charger_control_registers_props.sv
`timescale 1ns/10ps
module charger_control_registers_props (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic charging_in,
    input wire logic status_event_in,
    input wire logic safety_timer_kick_out,
    input wire logic status_out,
    input wire logic status_oe_out,
    input wire logic [1:0] input_current_limit_out,
    input wire logic [1:0] weak_battery_threshold_out,
    input wire logic termination_enable_out,
    input wire logic charge_enable_n_out,
    input wire logic high_impedance_select_out,
    input wire logic operating_mode_select_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic [7:0] cfg;
    assign cfg = {input_current_limit_out, weak_battery_threshold_out, termination_enable_out,
        charge_enable_n_out, high_impedance_select_out, operating_mode_select_out};
    // ****************
    // assertions
    // ****************
    sda_open_drain_a: assert property (sda_out == 1'b0)
        else $error("sda value not zero");
    stat_open_drain_a: assert property (status_out == 1'b0)
        else $error("status value not zero");
    ack_rise_a: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("sda pulled while scl high");
    ack_release_a: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("sda released while scl high");
    // pulse counter loads one edge after the event, the pin flop one edge later
    event_pulse_a: assert property (status_event_in |-> ##2 status_oe_out [*8])
        else $error("event pulse missing");
    stat_quiet_a: assert property (
        !charging_in && !status_event_in && !$past(status_event_in) && !status_oe_out
        |=> !status_oe_out)
        else $error("status pulled without cause");
    kick_single_a: assert property (safety_timer_kick_out |=> !safety_timer_kick_out)
        else $error("kick longer than one cycle");
    kick_on_write_a: assert property (
        $rose(safety_timer_kick_out) |-> ##[0:3] sda_oe_out)
        else $error("kick outside a write");
    cfg_on_write_a: assert property (cfg != $past(cfg) |-> ##[0:3] sda_oe_out)
        else $error("config changed outside a write");
    reset_vals_a: assert property ($rose(reset_n_in) |-> cfg == 8'h34
        && !sda_oe_out && !status_oe_out && !safety_timer_kick_out)
        else $error("bad values after reset");
endmodule : charger_control_registers_props

bind charger_control_registers charger_control_registers_props charger_control_registers_props_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .charging_in(charging_in), .status_event_in(status_event_in),
    .safety_timer_kick_out(safety_timer_kick_out), .status_out(status_out),
    .status_oe_out(status_oe_out), .input_current_limit_out(input_current_limit_out),
    .weak_battery_threshold_out(weak_battery_threshold_out),
    .termination_enable_out(termination_enable_out),
    .charge_enable_n_out(charge_enable_n_out),
    .high_impedance_select_out(high_impedance_select_out),
    .operating_mode_select_out(operating_mode_select_out)
);

// file: bench/charger_control_registers_tb.sv
`timescale 1ns/10ps
module charger_control_registers_tb;
    localparam logic [6:0] ADDR = charger_regs_pkg::DEVICE_ADDRESS;
    logic clk_in;
    logic reset_n_in;
    logic charging;
    logic status_event;
    logic boost;
    logic [2:0] fault;
    logic [7:0] kick_cnt;
    logic [7:0] rd[$];
    wire scl;
    wire sda;
    wire sda_oe;
    wire stat_oe;
    wire kick;
    wire [7:0] cfg;
    int error_cnt;
    int checked;
    charger_control_registers charger_control_registers_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(sda_oe), .charging_in(charging),
        .status_event_in(status_event), .boost_active_in(boost), .fault_code_in(fault),
        .safety_timer_kick_out(kick), .status_out(), .status_oe_out(stat_oe),
        .input_current_limit_out(cfg[7:6]), .weak_battery_threshold_out(cfg[5:4]),
        .termination_enable_out(cfg[3]), .charge_enable_n_out(cfg[2]),
        .high_impedance_select_out(cfg[1]), .operating_mode_select_out(cfg[0])
    );
    i2c_host_model i2c_host_model_inst (
        .clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda)
    );
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (kick === 1'b1) kick_cnt <= kick_cnt + 8'h01;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_reg0(input logic [7:0] exp);
        i2c_host_model_inst.read_regs(8'h00, 1, rd);
        check(rd[0], exp);
    endtask : rd_reg0
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // ****************
    // tests
    // ****************
    initial begin
        reset_n_in = 1'b0;
        charging = 1'b0;
        status_event = 1'b0;
        boost = 1'b0;
        fault = 3'h0;
        kick_cnt = 8'h00;
        error_cnt = 0;
        checked = 0;
        tick(4);
        reset_n_in = 1'b1;
        tick(4);
        check(cfg, 8'h34);
        i2c_host_model_inst.read_regs(8'h00, 2, rd);
        check(rd[0], 8'h40);
        check(rd[1], 8'h34);
        $display("test reset done");
        i2c_host_model_inst.write_regs(ADDR, 8'h00, '{8'hbf, 8'h0a});
        check(kick_cnt, 8'h01);
        check(cfg, 8'h0a);
        check({7'h0, cfg[2]}, 8'h00);
        check({7'h0, cfg[1]}, 8'h01);
        i2c_host_model_inst.read_regs(8'h00, 2, rd);
        check(rd[0], 8'h00);
        check(rd[1], 8'h0a);
        // pointer 0xff wraps onto the first register
        i2c_host_model_inst.write_regs(ADDR, 8'hff, '{8'h12, 8'h40});
        rd_reg0(8'h40);
        check(kick_cnt, 8'h01);
        $display("test sequential done");
        for (int c = 0; c < 4; c++) begin
            i2c_host_model_inst.write_regs(ADDR, 8'h01, '{{c[1:0], c[1:0], 4'h1}});
            check(cfg, {c[1:0], c[1:0], 4'h1});
        end
        i2c_host_model_inst.write_regs(ADDR, 8'h01, '{8'h34});
        check(cfg, 8'h34);
        $display("test config done");
        boost = 1'b1;
        rd_reg0(8'h48);
        boost = 1'b0;
        for (int c = 1; c < 8; c++) begin
            fault = c[2:0];
            tick(2);
            fault = 3'h0;
            rd_reg0((c == 2 || c > 5) ? {5'h08, c[2:0]} : 8'h40);
            rd_reg0(8'h40);
        end
        fault = 3'h5;
        rd_reg0(8'h45);
        fault = 3'h0;
        $display("test status bits done");
        charging = 1'b1;
        tick(3);
        check({7'h0, stat_oe}, 8'h01);
        i2c_host_model_inst.write_regs(ADDR, 8'h00, '{8'h00});
        check({7'h0, stat_oe}, 8'h00);
        status_event = 1'b1;
        tick(1);
        status_event = 1'b0;
        tick(2);
        check({7'h0, stat_oe}, 8'h01);
        tick(1290);
        check({7'h0, stat_oe}, 8'h00);
        charging = 1'b0;
        i2c_host_model_inst.write_regs(ADDR, 8'h00, '{8'h40});
        $display("test status pin done");
        i2c_host_model_inst.write_regs(ADDR, 8'h05, '{8'h55});
        check({7'h0, i2c_host_model_inst.bus_nack}, 8'h00);
        i2c_host_model_inst.read_regs(8'h05, 1, rd);
        check(rd[0], 8'h00);
        i2c_host_model_inst.write_regs(7'h6a, 8'h01, '{8'h00});
        check({7'h0, i2c_host_model_inst.bus_nack}, 8'h01);
        check(cfg, 8'h34);
        $display("test refusals done");
        give_verdict();
    end
    initial begin
        // tests need roughly 40k cycles; keep the whole run under 60k
        repeat (60000) @(posedge clk_in);
        error_cnt++;
        give_verdict();
    end
endmodule : charger_control_registers_tb
